// >>> design/sest_tree.sv
// Status event summary tree: operation, questionable and measurement register sets.
// Assumes level condition inputs synchronous to mclk and a decoded command port.
`timescale 1ns/1ps
`default_nettype none

module sest_tree (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // Operation activity conditions
  input  wire logic        calibration_active,
  input  wire logic        acquisition_active,
  input  wire logic        trigger_wait,
  input  wire logic        gate_wait,
  input  wire logic        smoothing_settled,
  input  wire logic        sequence_running,
  input  wire logic        unit_idle,
  // Protection and output conditions
  input  wire logic        current_limited_output,
  input  wire logic        voltage_regulated_output,
  input  wire logic        overcurrent_trip,
  input  wire logic        overvoltage_trip,
  input  wire logic        overtemp_trip,
  input  wire logic        sense_leads_swapped,
  input  wire logic        terminals_live,
  // Measurement chain source
  input  wire logic        acquisition_chain_summary,
  // Command port
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [4:0]  cmd_addr,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic        clear_status,
  output logic             rsp_valid,
  output logic [15:0]      rsp_data,
  // Summaries toward the status byte
  output logic             operation_summary,
  output logic             questionable_byte_summary,
  output logic             measurement_summary
);
  import sest_pkg::*;

  sest_state_t s_q;
  sest_state_t s_d;

  function automatic logic summ(input logic [15:0] ev, input logic [15:0] en);
    summ = |(ev & en);
  endfunction : summ

  // Next event value; a set in the same cycle as a clear is kept.
  function automatic logic [15:0] latch(input logic [15:0] cur, input logic [15:0] set,
                                        input logic clr);
    latch = (clr ? ZERO16 : cur) | set;
  endfunction : latch

  ////////////////////////////////////////////////////////////////////////////////////////////

  logic [15:0] op_live;
  logic [15:0] q_live;
  logic        rd;
  logic        wr;

  always_comb begin
    op_live                = ZERO16;
    op_live[OP_CAL_BIT]    = calibration_active;
    op_live[OP_ACQ_BIT]    = acquisition_active;
    op_live[OP_TRIG_BIT]   = trigger_wait;
    op_live[OP_GATE_BIT]   = gate_wait;
    op_live[OP_SMOOTH_BIT] = smoothing_settled;
    op_live[OP_SEQ_BIT]    = sequence_running;
    op_live[OP_IDLE_BIT]   = unit_idle;
    q_live                 = ZERO16;
    q_live[Q_CL_BIT]       = current_limited_output;
    q_live[Q_VR_BIT]       = voltage_regulated_output;
    q_live[Q_OC_BIT]       = overcurrent_trip;
    q_live[Q_OV_BIT]       = overvoltage_trip;
    q_live[Q_OT_BIT]       = overtemp_trip;
    q_live[Q_SLS_BIT]      = sense_leads_swapped;
    q_live[Q_LIVE_BIT]     = terminals_live;
    rd                     = cmd_valid & ~cmd_write;
    wr                     = cmd_valid & cmd_write;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic [15:0] op_act_set;
    logic [15:0] q_prot_set;
    logic [15:0] op_chain_set;
    logic [15:0] q_chain_set;
    logic [15:0] m_chain_set;
    logic [15:0] op_top_set;
    logic [15:0] q_top_set;
    logic [15:0] m_top_set;
    logic        carry_ok;
    // A clear drops what a lower level of the tree passes up in that cycle (acquisition_chain_summary still sets m_chain_ev); otherwise a stale
    // lower event would relatch an upper register that the same clear empties.
    carry_ok     = !clear_status;
    // Activity events latch on a rising condition, so a level held high does not
    // refill the register right after software reads it clear.
    op_act_set   = op_live & ~s_q.op_act_cond & OP_ACT_MASK;
    q_prot_set   = q_live & ~s_q.q_prot_cond & Q_PROT_MASK;
    op_chain_set = (carry_ok && summ(s_q.op_act_ev, s_q.op_act_en)) ? CHAIN_MASK : ZERO16;
    q_chain_set  = (carry_ok && summ(s_q.q_prot_ev, s_q.q_prot_en)) ? CHAIN_MASK : ZERO16;
    m_chain_set  = acquisition_chain_summary ? CHAIN_MASK : ZERO16;
    op_top_set   = (carry_ok && summ(s_q.op_chain_ev, s_q.op_chain_en)) ? TOP_MASK : ZERO16;
    q_top_set    = (carry_ok && summ(s_q.q_chain_ev, s_q.q_chain_en)) ? TOP_MASK : ZERO16;
    m_top_set    = (carry_ok && summ(s_q.m_chain_ev, s_q.m_chain_en)) ? TOP_MASK : ZERO16;
    s_d          = s_q;

    s_d.op_act_cond = op_live & OP_ACT_MASK;
    s_d.q_prot_cond = q_live & Q_PROT_MASK;

    s_d.op_act_ev   = latch(s_q.op_act_ev, op_act_set,
                            clear_status | (rd && cmd_addr == ID_OP_ACT_EV));
    s_d.q_prot_ev   = latch(s_q.q_prot_ev, q_prot_set,
                            clear_status | (rd && cmd_addr == ID_Q_PROT_EV));
    s_d.op_chain_ev = latch(s_q.op_chain_ev, op_chain_set,
                            clear_status | (rd && cmd_addr == ID_OP_CHAIN_EV));
    s_d.q_chain_ev  = latch(s_q.q_chain_ev, q_chain_set,
                            clear_status | (rd && cmd_addr == ID_Q_CHAIN_EV));
    s_d.m_chain_ev  = latch(s_q.m_chain_ev, m_chain_set,
                            clear_status | (rd && cmd_addr == ID_M_CHAIN_EV));
    s_d.op_top_ev   = latch(s_q.op_top_ev, op_top_set,
                            clear_status | (rd && cmd_addr == ID_OP_TOP_EV));
    s_d.q_top_ev    = latch(s_q.q_top_ev, q_top_set,
                            clear_status | (rd && cmd_addr == ID_Q_TOP_EV));
    s_d.m_top_ev    = latch(s_q.m_top_ev, m_top_set,
                            clear_status | (rd && cmd_addr == ID_M_TOP_EV));

    // Enable writes keep only the bits in use, so unused bits always read zero.
    if (wr) begin
      unique case (cmd_addr)
        ID_OP_TOP_EN:   s_d.op_top_en   = cmd_wdata & TOP_MASK;
        ID_OP_CHAIN_EN: s_d.op_chain_en = cmd_wdata & CHAIN_MASK;
        ID_OP_ACT_EN:   s_d.op_act_en   = cmd_wdata & OP_ACT_MASK;
        ID_Q_TOP_EN:    s_d.q_top_en    = cmd_wdata & TOP_MASK;
        ID_Q_CHAIN_EN:  s_d.q_chain_en  = cmd_wdata & CHAIN_MASK;
        ID_Q_PROT_EN:   s_d.q_prot_en   = cmd_wdata & Q_PROT_MASK;
        ID_M_TOP_EN:    s_d.m_top_en    = cmd_wdata & TOP_MASK;
        ID_M_CHAIN_EN:  s_d.m_chain_en  = cmd_wdata & CHAIN_MASK;
        default: ;
      endcase
    end

    // Reads return the value before any clear caused by the same read.
    s_d.rsp_valid = cmd_valid;
    s_d.rsp_data  = ZERO16;
    if (rd) begin
      unique case (cmd_addr)
        ID_OP_TOP_EV:   s_d.rsp_data = s_q.op_top_ev;
        ID_OP_TOP_EN:   s_d.rsp_data = s_q.op_top_en;
        ID_OP_CHAIN_EV: s_d.rsp_data = s_q.op_chain_ev;
        ID_OP_CHAIN_EN: s_d.rsp_data = s_q.op_chain_en;
        ID_OP_ACT_EV:   s_d.rsp_data = s_q.op_act_ev;
        ID_OP_ACT_EN:   s_d.rsp_data = s_q.op_act_en;
        ID_OP_ACT_COND: s_d.rsp_data = s_q.op_act_cond;
        ID_Q_TOP_EV:    s_d.rsp_data = s_q.q_top_ev;
        ID_Q_TOP_EN:    s_d.rsp_data = s_q.q_top_en;
        ID_Q_CHAIN_EV:  s_d.rsp_data = s_q.q_chain_ev;
        ID_Q_CHAIN_EN:  s_d.rsp_data = s_q.q_chain_en;
        ID_Q_PROT_EV:   s_d.rsp_data = s_q.q_prot_ev;
        ID_Q_PROT_EN:   s_d.rsp_data = s_q.q_prot_en;
        ID_Q_PROT_COND: s_d.rsp_data = s_q.q_prot_cond;
        ID_M_TOP_EV:    s_d.rsp_data = s_q.m_top_ev;
        ID_M_TOP_EN:    s_d.rsp_data = s_q.m_top_en;
        ID_M_CHAIN_EV:  s_d.rsp_data = s_q.m_chain_ev;
        ID_M_CHAIN_EN:  s_d.rsp_data = s_q.m_chain_en;
        default:        s_d.rsp_data = ZERO16;
      endcase
    end

    // Summaries are taken from present contents every cycle, so a mask change alone
    // moves them one edge later.
    s_d.op_sum = summ(s_q.op_top_ev, s_q.op_top_en);
    s_d.q_sum  = summ(s_q.q_top_ev, s_q.q_top_en);
    s_d.m_sum  = summ(s_q.m_top_ev, s_q.m_top_en);
  end

  ////////////////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign rsp_valid                 = s_q.rsp_valid;
  assign rsp_data                  = s_q.rsp_data;
  assign operation_summary         = s_q.op_sum;
  assign questionable_byte_summary = s_q.q_sum;
  assign measurement_summary       = s_q.m_sum;

endmodule : sest_tree

`default_nettype wire

// >>> design/sest_pkg.sv
// Constants and types for the status event summary tree.
// Assumes a decoded register command port driven by the host text command parser.
package sest_pkg;

  localparam int unsigned W = 16;

  // Register identifiers on the command port.
  localparam logic [4:0] ID_OP_TOP_EV    = 5'h00;
  localparam logic [4:0] ID_OP_TOP_EN    = 5'h01;
  localparam logic [4:0] ID_OP_CHAIN_EV  = 5'h02;
  localparam logic [4:0] ID_OP_CHAIN_EN  = 5'h03;
  localparam logic [4:0] ID_OP_ACT_EV    = 5'h04;
  localparam logic [4:0] ID_OP_ACT_EN    = 5'h05;
  localparam logic [4:0] ID_OP_ACT_COND  = 5'h06;
  localparam logic [4:0] ID_Q_TOP_EV     = 5'h08;
  localparam logic [4:0] ID_Q_TOP_EN     = 5'h09;
  localparam logic [4:0] ID_Q_CHAIN_EV   = 5'h0A;
  localparam logic [4:0] ID_Q_CHAIN_EN   = 5'h0B;
  localparam logic [4:0] ID_Q_PROT_EV    = 5'h0C;
  localparam logic [4:0] ID_Q_PROT_EN    = 5'h0D;
  localparam logic [4:0] ID_Q_PROT_COND  = 5'h0E;
  localparam logic [4:0] ID_M_TOP_EV     = 5'h10;
  localparam logic [4:0] ID_M_TOP_EN     = 5'h11;
  localparam logic [4:0] ID_M_CHAIN_EV   = 5'h12;
  localparam logic [4:0] ID_M_CHAIN_EN   = 5'h13;

  // Field positions.
  localparam int unsigned TOP_BIT        = 13;
  localparam int unsigned CHAIN_BIT      = 1;
  localparam int unsigned OP_CAL_BIT     = 0;
  localparam int unsigned OP_ACQ_BIT     = 4;
  localparam int unsigned OP_TRIG_BIT    = 5;
  localparam int unsigned OP_GATE_BIT    = 6;
  localparam int unsigned OP_SMOOTH_BIT  = 8;
  localparam int unsigned OP_SEQ_BIT     = 9;
  localparam int unsigned OP_IDLE_BIT    = 10;
  localparam int unsigned Q_CL_BIT       = 0;
  localparam int unsigned Q_VR_BIT       = 1;
  localparam int unsigned Q_OC_BIT       = 2;
  localparam int unsigned Q_OV_BIT       = 3;
  localparam int unsigned Q_OT_BIT       = 4;
  localparam int unsigned Q_SLS_BIT      = 5;
  localparam int unsigned Q_LIVE_BIT     = 6;

  // Masks of the bits in use.
  localparam logic [15:0] TOP_MASK       = 16'h2000;
  localparam logic [15:0] CHAIN_MASK     = 16'h0002;
  localparam logic [15:0] OP_ACT_MASK    = 16'h0771;
  localparam logic [15:0] Q_PROT_MASK    = 16'h007F;
  localparam logic [15:0] ZERO16         = 16'h0000;

  typedef struct packed {
    logic [15:0] op_top_ev;
    logic [15:0] op_top_en;
    logic [15:0] op_chain_ev;
    logic [15:0] op_chain_en;
    logic [15:0] op_act_cond;
    logic [15:0] op_act_ev;
    logic [15:0] op_act_en;
    logic [15:0] q_top_ev;
    logic [15:0] q_top_en;
    logic [15:0] q_chain_ev;
    logic [15:0] q_chain_en;
    logic [15:0] q_prot_cond;
    logic [15:0] q_prot_ev;
    logic [15:0] q_prot_en;
    logic [15:0] m_top_ev;
    logic [15:0] m_top_en;
    logic [15:0] m_chain_ev;
    logic [15:0] m_chain_en;
    logic        rsp_valid;
    logic [15:0] rsp_data;
    logic        op_sum;
    logic        q_sum;
    logic        m_sum;
  } sest_state_t;

  localparam sest_state_t STATE_RESET = '0;

endpackage : sest_pkg

// >>> bench/sest_tree_chk.sv
// Port checker for the status event summary tree.
// Assumes it is bound to sest_tree and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module sest_chk
  import sest_pkg::*;
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        nrst,
  // Condition inputs
  input wire logic        calibration_active,
  input wire logic        acquisition_active,
  input wire logic        trigger_wait,
  input wire logic        gate_wait,
  input wire logic        smoothing_settled,
  input wire logic        sequence_running,
  input wire logic        unit_idle,
  // Command port and summaries
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic [4:0]  cmd_addr,
  input wire logic [15:0] cmd_wdata,
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic        operation_summary,
  input wire logic        questionable_byte_summary,
  input wire logic        measurement_summary
);
  logic [15:0] op_cond_v;
  logic        rd_act;
  logic        rd_cond;
  assign op_cond_v = {5'h00, unit_idle, sequence_running, smoothing_settled, 1'h0, gate_wait,
                      trigger_wait, acquisition_active, 3'h0, calibration_active};
  assign rd_act = cmd_valid && !cmd_write && cmd_addr == ID_OP_ACT_EV;
  assign rd_cond = cmd_valid && !cmd_write && cmd_addr == ID_OP_ACT_COND;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  ////////////////////////
  a_rsp_follows_cmd: assert property (cmd_valid |=> rsp_valid)
    else $error("command without response");
  a_rsp_without_cmd: assert property (!cmd_valid |=> !rsp_valid && rsp_data == ZERO16)
    else $error("response without command");
  a_op_top_bits: assert property (cmd_valid && !cmd_write && cmd_addr == ID_OP_TOP_EV
    |=> (rsp_data & ~TOP_MASK) == ZERO16) else $error("unused operation top bit set");
  a_q_top_bits: assert property (cmd_valid && !cmd_write && cmd_addr == ID_Q_TOP_EV
    |=> (rsp_data & ~TOP_MASK) == ZERO16) else $error("unused questionable top bit set");
  a_m_top_bits: assert property (cmd_valid && !cmd_write && cmd_addr == ID_M_TOP_EV
    |=> (rsp_data & ~TOP_MASK) == ZERO16) else $error("unused measurement top bit set");
  a_reset_quiet: assert property (disable iff (1'h0) !nrst |=> !rsp_valid
    && !operation_summary && !questionable_byte_summary && !measurement_summary)
    else $error("output active out of reset");
  a_en_readback: assert property (cmd_valid && cmd_write && cmd_addr == ID_OP_TOP_EN ##1
    rd_act == 1'h0 && cmd_valid && !cmd_write && cmd_addr == ID_OP_TOP_EN
    |=> rsp_data == ($past(cmd_wdata, 2) & TOP_MASK)) else $error("enable readback wrong");
  a_cond_live: assert property (rd_cond && $past(nrst) && $stable(op_cond_v)
    |=> rsp_data == $past(op_cond_v)) else $error("condition read not live");
  a_read_clears: assert property (rd_act && $past(nrst) && $stable(op_cond_v) ##1
    rd_act && $stable(op_cond_v) |=> rsp_data == ZERO16) else $error("read did not clear");
endmodule : sest_chk
bind sest_tree sest_chk u_chk (.mclk(mclk), .nrst(nrst),
  .calibration_active(calibration_active), .acquisition_active(acquisition_active),
  .trigger_wait(trigger_wait), .gate_wait(gate_wait), .smoothing_settled(smoothing_settled),
  .sequence_running(sequence_running), .unit_idle(unit_idle), .cmd_valid(cmd_valid),
  .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .operation_summary(operation_summary),
  .questionable_byte_summary(questionable_byte_summary),
  .measurement_summary(measurement_summary));
`default_nettype wire

// >>> bench/sest_tree_tb.sv
// Self-checking testbench for the status event summary tree.
// Assumes the package, the design and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module sest_tree_tb;
  import sest_pkg::*;
  logic        mclk = 1'h0;
  logic        nrst = 1'h0;
  logic [6:0]  op_in = 7'h00;
  logic [6:0]  q_in = 7'h00;
  logic        acq = 1'h0;
  logic        cmd_valid = 1'h0;
  logic        cmd_write = 1'h0;
  logic [4:0]  cmd_addr = 5'h00;
  logic [15:0] cmd_wdata = 16'h0000;
  logic        clr = 1'h0;
  logic        rsp_valid;
  logic [15:0] rsp_data;
  logic        op_sum;
  logic        q_sum;
  logic        m_sum;
  logic [15:0] got;
  int          bad_count = 0;
  int          total_checks = 0;
  logic [4:0]  en_id [8] = '{ID_OP_TOP_EN, ID_OP_CHAIN_EN, ID_OP_ACT_EN, ID_Q_TOP_EN,
                             ID_Q_CHAIN_EN, ID_Q_PROT_EN, ID_M_TOP_EN, ID_M_CHAIN_EN};
  logic [15:0] en_m [8] = '{16'h2000, 16'h0002, 16'h0771, 16'h2000, 16'h0002, 16'h007F,
                            16'h2000, 16'h0002};
  logic [15:0] op_w [7] = '{16'h0001, 16'h0010, 16'h0020, 16'h0040, 16'h0100, 16'h0200,
                            16'h0400};
  always #2 mclk = ~mclk;
  sest_tree u_dut (.mclk(mclk), .nrst(nrst), .calibration_active(op_in[0]),
    .acquisition_active(op_in[1]), .trigger_wait(op_in[2]), .gate_wait(op_in[3]),
    .smoothing_settled(op_in[4]), .sequence_running(op_in[5]), .unit_idle(op_in[6]),
    .current_limited_output(q_in[0]), .voltage_regulated_output(q_in[1]),
    .overcurrent_trip(q_in[2]), .overvoltage_trip(q_in[3]), .overtemp_trip(q_in[4]),
    .sense_leads_swapped(q_in[5]), .terminals_live(q_in[6]), .acquisition_chain_summary(acq),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .clear_status(clr), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .operation_summary(op_sum), .questionable_byte_summary(q_sum),
    .measurement_summary(m_sum));
  ////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // The strobe stays up so that commands can run back to back; idle drops it.
  task automatic cmd(input logic wr, input logic [4:0] a, input logic [15:0] wd);
    cmd_valid = 1'h1;
    cmd_write = wr;
    cmd_addr = a;
    cmd_wdata = wd;
    @(negedge mclk);
    got = rsp_data;
    chk("response strobe", 16'h0001, {15'h0000, rsp_valid});
  endtask : cmd
  task automatic idle(input int n);
    cmd_valid = 1'h0;
    repeat (n) @(negedge mclk);
  endtask : idle
  task automatic rd(input logic [4:0] a, input logic [15:0] e, input string w);
    cmd(1'h0, a, 16'h0000);
    chk(w, e, got);
  endtask : rd
  task automatic pulse_clr();
    clr = 1'h1;
    @(negedge mclk);
    clr = 1'h0;
    idle(4);
  endtask : pulse_clr
  ////////////////////////
  task automatic test_reset_map();
    for (int i = 0; i < 32; i++) rd(5'(i), ZERO16, "register after reset");
    idle(1);
  endtask : test_reset_map
  task automatic test_enables();
    for (int i = 0; i < 8; i++) begin
      cmd(1'h1, en_id[i], 16'hFFFF);
      rd(en_id[i], en_m[i], "enable readback");
    end
    cmd(1'h1, ID_OP_ACT_COND, 16'hFFFF);
    rd(ID_OP_ACT_COND, ZERO16, "condition write");
    idle(1);
  endtask : test_enables
  task automatic test_activity();
    for (int i = 0; i < 7; i++) begin
      op_in = 7'h01 << i;
      idle(5);
      chk("operation summary", 16'h0001, {15'h0000, op_sum});
      rd(ID_OP_ACT_COND, op_w[i], "activity condition");
      rd(ID_OP_ACT_EV, op_w[i], "activity event");
      rd(ID_OP_ACT_EV, ZERO16, "activity after read");
      op_in = 7'h00;
      idle(1);
      pulse_clr();
      chk("operation cleared", 16'h0000, {15'h0000, op_sum});
    end
  endtask : test_activity
  task automatic test_mask();
    op_in = 7'h40;
    idle(5);
    cmd(1'h1, ID_OP_TOP_EN, ZERO16);
    idle(2);
    chk("masked summary", 16'h0000, {15'h0000, op_sum});
    cmd(1'h1, ID_OP_TOP_EN, 16'h2000);
    idle(2);
    chk("unmasked summary", 16'h0001, {15'h0000, op_sum});
    rd(ID_OP_CHAIN_EV, 16'h0002, "operation chain");
    rd(ID_OP_TOP_EV, 16'h2000, "operation top");
    idle(1);
    pulse_clr();
    op_in = 7'h00;
  endtask : test_mask
  task automatic test_protection();
    for (int i = 0; i < 7; i++) begin
      q_in = 7'h01 << i;
      idle(5);
      chk("questionable summary", 16'h0001, {15'h0000, q_sum});
      rd(ID_Q_PROT_COND, 16'h0001 << i, "protection condition");
      rd(ID_Q_CHAIN_EV, 16'h0002, "questionable chain");
      idle(1);
      pulse_clr();
      chk("questionable cleared", 16'h0000, {15'h0000, q_sum});
      rd(ID_Q_PROT_EV, ZERO16, "protection after clear");
      idle(1);
      q_in = 7'h00;
    end
  endtask : test_protection
  task automatic test_measure();
    acq = 1'h1;
    idle(4);
    chk("measurement summary", 16'h0001, {15'h0000, m_sum});
    rd(ID_M_TOP_EV, 16'h2000, "measurement top");
    idle(1);
    acq = 1'h0;
    pulse_clr();
    chk("measurement cleared", 16'h0000, {15'h0000, m_sum});
  endtask : test_measure
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////
  initial begin
    repeat (12) @(negedge mclk);
    nrst = 1'h1;
    idle(2);
    test_reset_map();
    test_enables();
    test_activity();
    test_mask();
    test_protection();
    test_measure();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    report_and_stop();
  end
endmodule : sest_tree_tb
`default_nettype wire
